// ==== serial_far_end.sv ====
// far-end serial master that clocks one byte into the block, msb first
`timescale 1ns/1ps
`default_nettype none

module serial_far_end (
  // frame request
  input wire logic go,
  input wire logic [7:0] tx_byte,
  // pins toward the block
  output logic sclk,
  output logic sdata,
  output logic busy
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    busy = 1'b0;
  end

  // clock stands low between frames; each bit is held across both of its
  // edges, so either edge polarity samples the same bit
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sdata = tx_byte[i];
      #20 sclk = 1'b1;
      #40 sclk = 1'b0;
      #20;
    end
    // a released line must not keep showing the last bit
    sdata = ~sdata;
    busy = 1'b0;
  end
endmodule : serial_far_end

`default_nettype wire

// ==== serial_shift_clock_select.sv ====
// serial shift interface: clock source selection, strobes and pin routing
`timescale 1ns/1ps
`default_nettype none

module serial_shift_clock_select (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer compare match event, same clock domain
  input wire logic tc0_match,
  // pin group b and pin group a
  input wire logic [2:0] pb_in,
  input wire logic [2:0] pa_in,
  output serial_pkg::pins_s pb_pins,
  output serial_pkg::pins_s pa_pins
);
  import serial_pkg::*;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  // two-stage input synchronisers; stage one is read only by stage two
  logic [5:0] in_meta_r, in_sync_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      in_meta_r <= {pa_in, pb_in};
      in_sync_r <= in_meta_r;
    end
  end

  // registers
  logic [1:0] wm_r, wm_nxt, cs_r, cs_nxt;
  logic cnt_sel_r, cnt_sel_nxt, clk_port_r, clk_port_nxt;
  logic ovf_r, ovf_nxt, pos_r, pos_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] data_r, data_nxt;
  logic do_latch_r, do_latch_nxt, di_prev_r, di_prev_nxt;
  logic sclk_prev_r, sclk_prev_nxt;
  logic [2:0] dir_r, dir_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  pins_s pb_r, pb_nxt, pa_r, pa_nxt;

  // bus strobes
  logic acc_done, wr_en, rd_en;
  logic wr_ctrl, strobe_wr, toggle_wr;
  assign acc_done = psel && penable && pready_r;
  assign wr_en = acc_done && pwrite;
  assign rd_en = acc_done && !pwrite;
  assign wr_ctrl = wr_en && is_reg(paddr, OFF_CTRL);
  assign strobe_wr = wr_ctrl && pwdata[CTRL_STROBE];
  assign toggle_wr = wr_ctrl && pwdata[CTRL_TOGGLE];

  // selected pin group inputs after synchronising; inputs act in every
  // wire mode, only outputs depend on it
  logic di_in, sclk_in;
  assign di_in = pos_r ? in_sync_r[3+PIN_DI] : in_sync_r[PIN_DI];
  assign sclk_in = pos_r ? in_sync_r[3+PIN_CLK] : in_sync_r[PIN_CLK];

  // strobe shifts in last cycle's sample, pin edges the current one; the
  // fifo must see the same bit as the register or a strobe byte is torn
  logic shift_bit;
  assign shift_bit = (cs_r == CS_STROBE) ? di_prev_r : di_in;

  logic ext_mode, rise, fall, samp_edge, latch_edge;
  logic shift_ev, count_ev, stall, wrap;
  logic fifo_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  assign ext_mode = cs_r[1];
  assign rise = sclk_in && !sclk_prev_r;
  assign fall = !sclk_in && sclk_prev_r;
  assign samp_edge = cs_r[0] ? fall : rise;
  assign latch_edge = cs_r[0] ? rise : fall;
  // a full receive fifo stalls all clocking so no completed byte is lost
  assign stall = !fifo_ready;

  always_comb begin
    shift_ev = 1'b0;
    count_ev = 1'b0;
    if (cs_r == CS_STROBE) begin
      shift_ev = strobe_wr;
      count_ev = strobe_wr;
    end else if (cs_r == CS_TIMER) begin
      shift_ev = tc0_match;
      count_ev = tc0_match;
    end else begin
      shift_ev = samp_edge;
      count_ev = cnt_sel_r ? toggle_wr : (rise || fall);
    end
    if (stall) begin
      shift_ev = 1'b0;
      count_ev = 1'b0;
    end
  end
  assign wrap = count_ev && (cnt_r == CNT_MAX);

  shift_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) rx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wrap),
    .in_ready(fifo_ready),
    .in_data(shift_ev ? {data_r[6:0], shift_bit} : data_r),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );
  assign fifo_pop = rd_en && is_reg(paddr, OFF_RXFIFO);

  // core state
  always_comb begin
    wm_nxt = wm_r;
    cs_nxt = cs_r;
    cnt_sel_nxt = cnt_sel_r;
    pos_nxt = pos_r;
    dir_nxt = dir_r;
    clk_port_nxt = clk_port_r;
    cnt_nxt = cnt_r;
    ovf_nxt = ovf_r;
    data_nxt = data_r;
    do_latch_nxt = do_latch_r;
    di_prev_nxt = di_in;
    sclk_prev_nxt = sclk_in;
    if (wr_ctrl) begin
      wm_nxt = pwdata[CTRL_WM_LO+1:CTRL_WM_LO];
      cs_nxt = pwdata[CTRL_CS_LO+1:CTRL_CS_LO];
      // kept as counter source select, never read back
      cnt_sel_nxt = pwdata[CTRL_STROBE];
    end
    if (toggle_wr) begin
      clk_port_nxt = !clk_port_r;
    end
    if (wr_en && is_reg(paddr, OFF_PINPOS)) begin
      pos_nxt = pwdata[0];
    end
    if (wr_en && is_reg(paddr, OFF_DIR)) begin
      dir_nxt = pwdata[2:0];
    end
    if (shift_ev) begin
      data_nxt = {data_r[6:0], shift_bit};
    end
    if (wr_en && is_reg(paddr, OFF_DATA)) begin
      data_nxt = pwdata[7:0];
    end
    if (count_ev) begin
      cnt_nxt = cnt_r + 4'h1;
    end
    if (wr_en && is_reg(paddr, OFF_STATUS)) begin
      cnt_nxt = pwdata[3:0];
      if (pwdata[STAT_OVF]) begin
        ovf_nxt = 1'b0;
      end
    end
    if (wrap) begin
      ovf_nxt = 1'b1;
    end
    if (!ext_mode) begin
      do_latch_nxt = data_nxt[7];
    end else if (latch_edge) begin
      do_latch_nxt = data_r[7];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wm_r <= WM_OFF;
      cs_r <= CS_STROBE;
      cnt_sel_r <= 1'b0;
      pos_r <= 1'b0;
      dir_r <= DIR_RST;
      clk_port_r <= CLK_PORT_RST;
      cnt_r <= '0;
      ovf_r <= 1'b0;
      data_r <= DATA_RST;
      do_latch_r <= 1'b0;
      di_prev_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      wm_r <= wm_nxt;
      cs_r <= cs_nxt;
      cnt_sel_r <= cnt_sel_nxt;
      pos_r <= pos_nxt;
      dir_r <= dir_nxt;
      clk_port_r <= clk_port_nxt;
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
      data_r <= data_nxt;
      do_latch_r <= do_latch_nxt;
      di_prev_r <= di_prev_nxt;
      sclk_prev_r <= sclk_prev_nxt;
    end
  end

  // pins: outputs registered, so pins follow the core one cycle later
  pins_s grp;
  always_comb begin
    grp.o = '0;
    grp.oe = '0;
    grp.o[PIN_CLK] = clk_port_r;
    grp.oe[PIN_CLK] = dir_r[PIN_CLK];
    if (wm_r == WM_THREE) begin
      grp.o[PIN_DO] = do_latch_r;
      grp.oe[PIN_DO] = dir_r[PIN_DO];
    end else if (wm_r[1]) begin
      // open drain: drive low only, enable high while pulling
      grp.o[PIN_CLK] = 1'b0;
      grp.oe[PIN_DI] = dir_r[PIN_DI] && !do_latch_r;
      grp.oe[PIN_CLK] = dir_r[PIN_CLK] &&
        (!clk_port_r || (wm_r == WM_HOLD && ovf_r));
    end
    pb_nxt = pos_r ? '0 : grp;
    pa_nxt = pos_r ? grp : '0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pb_r <= '0;
      pa_r <= '0;
    end else begin
      pb_r <= pb_nxt;
      pa_r <= pa_nxt;
    end
  end
  assign pb_pins = pb_r;
  assign pa_pins = pa_r;

  // apb: one wait state, read data and error registered with pready
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      prdata_nxt = '0;
      if (is_reg(paddr, OFF_CTRL)) begin
        // strobe and toggle bits read zero
        prdata_nxt[7:0] = {2'h0, wm_r, cs_r, 2'h0};
      end else if (is_reg(paddr, OFF_STATUS)) begin
        prdata_nxt[7:0] = {fifo_valid, ovf_r, 2'h0, cnt_r};
      end else if (is_reg(paddr, OFF_DATA)) begin
        prdata_nxt[7:0] = data_r;
      end else if (is_reg(paddr, OFF_PINPOS)) begin
        prdata_nxt[7:0] = {7'h00, pos_r};
      end else if (is_reg(paddr, OFF_RXFIFO)) begin
        prdata_nxt[7:0] = fifo_valid ? fifo_data : 8'h00;
      end else if (is_reg(paddr, OFF_DIR)) begin
        prdata_nxt[7:0] = {5'h00, dir_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_strobe_counts: assert property (
    (cs_r == CS_STROBE && strobe_wr && !stall && !is_reg(paddr, OFF_STATUS))
    |=> (cnt_r == $past(cnt_r) + 4'h1)
  ) else $error("strobe write did not count by one");

  a_strobe_shift_bit: assert property (
    (cs_r == CS_STROBE && strobe_wr && !stall)
    |=> (data_r == {$past(data_r[6:0]), $past(di_prev_r)})
  ) else $error("strobe shift took wrong input bit");

  a_timer_clocks: assert property (
    (cs_r == CS_TIMER && tc0_match && !stall && !wr_en)
    |=> (cnt_r == $past(cnt_r) + 4'h1) && (data_r[0] == $past(di_in))
  ) else $error("timer match did not clock register and counter");

  a_ext_edge_shift: assert property (
    (ext_mode && samp_edge && !stall && !wr_en)
    |=> (data_r == {$past(data_r[6:0]), $past(di_in)})
  ) else $error("pin clock edge did not shift data");

  a_latch_opposite: assert property (
    (ext_mode && !latch_edge && !wr_ctrl) |=> $stable(do_latch_r)
  ) else $error("output latch moved off the opposite edge");

  a_ctrl_reads_zero: assert property (
    (psel && penable && !pready_r && is_reg(paddr, OFF_CTRL))
    ##1 pready_r |-> (prdata_r[1:0] == 2'h0)
  ) else $error("strobe or toggle bit read as one");

  a_pinpos_reserved: assert property (
    (psel && penable && !pready_r && is_reg(paddr, OFF_PINPOS))
    |=> (prdata_r[7:1] == 7'h00) && (prdata_r[0] == $past(pos_r))
  ) else $error("pin position reserved bits not zero");

  a_toggle_inverts: assert property (
    toggle_wr |=> (clk_port_r != $past(clk_port_r))
    ##1 ($past(wm_r[1]) ||
    (($past(pos_r) ? pa_r.o[PIN_CLK] : pb_r.o[PIN_CLK]) == $past(clk_port_r)))
  ) else $error("toggle write did not invert clock port");

  a_wrap_flag: assert property (
    (count_ev && cnt_r == CNT_MAX) |=> (cnt_r == 4'h0 || $past(wr_en)) && ovf_r
  ) else $error("counter wrap did not raise flag");

  a_hold_scl: assert property (
    (wm_r == WM_HOLD && ovf_r && dir_r[PIN_CLK] && !wr_en)
    |=> (pos_r ? pa_r.oe[PIN_CLK] : pb_r.oe[PIN_CLK])
  ) else $error("clock line not held after overflow");

  a_route_group: assert property (
    (!pos_r && !wr_en) |=> (pa_r == '0)
  ) else $error("group a driven while group b selected");

  c_strobe: cover property (cs_r == CS_STROBE && strobe_wr && !stall);
  c_ext_byte: cover property (ext_mode && wrap);
  c_fifo_full: cover property (stall);
  c_hold: cover property (wm_r == WM_HOLD && ovf_r && dir_r[PIN_CLK]);
endmodule : serial_shift_clock_select

`default_nettype wire

// ==== shift_fifo.sv ====
// constants package and the small word fifo of the serial shift block
// Summary of operation
// - clock select 00: each strobe write clocks data register and counter, except while the fifo is full
// - external clock: output latch updates on edge opposite to sampling
// - strobe or timer source: output latch is transparent
// - clock select 01: timer compare match clocks register and counter
// - upper select set: pin clock shifts data, lower bit picks edge
// - external clock: strobe bit picks counter source, both edges or toggle
// - each strobe shifts exactly one bit and counts exactly one unless the fifo is full, then none
// - strobe changes output at once, shifts in previously sampled input
// - strobe and toggle bits always read as zero
// - toggle write inverts clock port value, pin driven only if output
// - external clock with strobe bit set: toggle write counts directly
// - pin position bits 7 to 1 always read zero
// - pin group select routes functions to group b or group a
// - data and clock inputs work in every wire mode
// - two-wire hold mode: clock line low from overflow until flag cleared
`timescale 1ns/1ps
`default_nettype none

package serial_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_PINPOS = 8'h0c;
  localparam logic [7:0] OFF_RXFIFO = 8'h10;
  localparam logic [7:0] OFF_DIR = 8'h14;
  // control register fields
  localparam int CTRL_WM_LO = 4;
  localparam int CTRL_CS_LO = 2;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_TOGGLE = 0;
  // status register fields
  localparam int STAT_FIFO_VALID = 7;
  localparam int STAT_OVF = 6;
  // pin indices inside a group
  localparam int PIN_DI = 0;
  localparam int PIN_DO = 1;
  localparam int PIN_CLK = 2;
  // clock source encodings
  localparam logic [1:0] CS_STROBE = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  // wire mode encodings
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_HOLD = 2'h3;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] DIR_RST = 3'h0;
  localparam logic CLK_PORT_RST = 1'b0;
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_W = 8;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } pins_s;
endpackage : serial_pkg

module shift_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0] count_r, count_nxt;
  logic push, pop;

  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage needs no reset; only words below count are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule : shift_fifo

`default_nettype wire

// ==== test_serial_shift_clock_select.sv ====
// self-checking bench of the serial shift clock select block
`timescale 1ns/1ps
`default_nettype none

module test_serial_shift_clock_select;
  import serial_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, tc0_match, go, err;
  logic [7:0] paddr, tx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sclk, sdata, busy;
  pins_s pb_pins, pa_pins;
  wire logic [2:0] pb_in;
  wire logic [2:0] pa_in;
  int fails, checked;

  // clock and output pins show the block's level while it drives, else sclk or a fixed level; data in is sdata on group b, 0 on group a
  assign pb_in = {pb_pins.oe[2] ? pb_pins.o[2] : sclk,
                  pb_pins.oe[1] ? pb_pins.o[1] : 1'b1, sdata};
  assign pa_in = {pa_pins.oe[2] ? pa_pins.o[2] : 1'b0,
                  pa_pins.oe[1] ? pa_pins.o[1] : 1'b1, 1'b0};

  serial_shift_clock_select serial_shift_clock_select_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tc0_match(tc0_match),
    .pb_in(pb_in), .pa_in(pa_in), .pb_pins(pb_pins), .pa_pins(pa_pins)
  );

  serial_far_end serial_far_end_inst (
    .go(go), .tx_byte(tx_byte), .sclk(sclk), .sdata(sdata), .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] cw(input logic [1:0] wm,
      input logic [1:0] cs, input logic s, input logic t);
    return {26'h0, wm, cs, s, t};
  endfunction : cw

  // one apb transfer, entered just after a rising edge; pready and read
  // data are read at the edge, before the design's registers move
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // pins lag core state, so let a few edges pass before looking
  task automatic pins_check(input pins_s b, input pins_s a);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({26'h0, pb_pins}, {26'h0, b});
    check({26'h0, pa_pins}, {26'h0, a});
    @(posedge clk_sys);
  endtask : pins_check

  task automatic send(input logic [7:0] b);
    int n;
    tx_byte <= b;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    while (busy && n < 100) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 100) begin
      fails++;
      end_of_test();
    end
    repeat (6) @(posedge clk_sys);
  endtask : send

  task automatic t_regs;
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, OFF_DIR, 32'h0);
    check(rd, {29'h0, DIR_RST});
    apb(1'b1, OFF_PINPOS, 32'hfe);
    apb(1'b0, OFF_PINPOS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_TIMER, 1'b1, 1'b0));
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd, cw(WM_THREE, CS_TIMER, 1'b0, 1'b0));
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("register test done");
  endtask : t_regs

  task automatic t_strobe;
    apb(1'b1, OFF_DIR, 32'h2);
    apb(1'b1, OFF_STATUS, 32'h40);
    apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_STROBE, 1'b0, 1'b0));
    apb(1'b1, OFF_DATA, 32'h5a);
    apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_STROBE, 1'b1, 1'b0));
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'hb4);
    check({31'h0, pb_pins.o[PIN_DO]}, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    // fill the fifo past full: the fifth strobe must be dropped
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFF_STATUS, 32'h4f);
      apb(1'b1, OFF_DATA, 32'h10 + i);
      apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_STROBE, 1'b1, 1'b0));
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd, (i < 4) ? 32'hc0 : 32'h8f);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, OFF_RXFIFO, 32'h0);
      check(rd, (i < 4) ? 32'h20 + 2 * i : 32'h0);
    end
    // the dropped fifth strobe never wrapped, so the flag stays clear
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h0f);
    $display("strobe and fifo test done");
  endtask : t_strobe

  task automatic t_timer;
    // leave strobe mode first: a strobe bit written while strobe mode still
    // stands is a real strobe
    apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_TIMER, 1'b0, 1'b0));
    apb(1'b1, OFF_STATUS, 32'h40);
    apb(1'b1, OFF_DATA, 32'h01);
    apb(1'b1, OFF_CTRL, cw(WM_THREE, CS_TIMER, 1'b1, 1'b0));
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    tc0_match <= 1'b1;
    @(posedge clk_sys);
    tc0_match <= 1'b0;
    repeat (2) @(posedge clk_sys);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'h02);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h01);
    $display("timer test done");
  endtask : t_timer

  task automatic t_toggle;
    apb(1'b1, OFF_DIR, 32'h0);
    apb(1'b1, OFF_CTRL, cw(WM_OFF, CS_STROBE, 1'b0, 1'b1));
    apb(1'b1, OFF_DIR, 32'h4);
    pins_check(6'h24, 6'h00);
    apb(1'b1, OFF_PINPOS, 32'h1);
    pins_check(6'h00, 6'h24);
    apb(1'b1, OFF_CTRL, cw(WM_OFF, CS_STROBE, 1'b0, 1'b1));
    pins_check(6'h00, 6'h04);
    apb(1'b1, OFF_PINPOS, 32'h0);
    $display("toggle and pin group test done");
  endtask : t_toggle

  task automatic t_ext;
    logic [7:0] b;
    apb(1'b1, OFF_DIR, 32'h2);
    for (int lo = 0; lo < 2; lo++) begin
      b = (lo == 0) ? 8'hc5 : 8'h3a;
      apb(1'b1, OFF_STATUS, 32'h40);
      apb(1'b1, OFF_CTRL, cw(WM_THREE, {1'b1, lo[0]}, 1'b0, 1'b0));
      send(b);
      @(negedge clk_sys);
      // falling sampling latches on the last rise, before the eighth shift,
      // so bit 0 of the earlier byte (1) is still on top
      check({31'h0, pb_pins.o[PIN_DO]}, {31'h0, (lo == 0) ? b[7] : 1'b1});
      @(posedge clk_sys);
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd, 32'hc0);
      apb(1'b0, OFF_RXFIFO, 32'h0);
      check(rd, {24'h0, b});
    end
    apb(1'b1, OFF_STATUS, 32'h40);
    apb(1'b1, OFF_CTRL, cw(WM_OFF, 2'h2, 1'b1, 1'b0));
    apb(1'b1, OFF_CTRL, cw(WM_OFF, 2'h2, 1'b1, 1'b1));
    send(8'h0f);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h01);
    apb(1'b0, OFF_DATA, 32'h0);
    check(rd, 32'h0f);
    $display("external clock test done");
  endtask : t_ext

  // clock port is high here, so only the overflow can pull the clock low
  task automatic t_hold;
    apb(1'b1, OFF_CTRL, cw(WM_HOLD, CS_STROBE, 1'b0, 1'b0));
    apb(1'b1, OFF_DIR, 32'h4);
    apb(1'b1, OFF_STATUS, 32'h4f);
    pins_check(6'h00, 6'h00);
    apb(1'b1, OFF_CTRL, cw(WM_HOLD, CS_STROBE, 1'b1, 1'b0));
    pins_check(6'h04, 6'h00);
    apb(1'b1, OFF_STATUS, 32'h40);
    pins_check(6'h00, 6'h00);
    apb(1'b0, OFF_RXFIFO, 32'h0);
    check(rd, 32'h1e);
    $display("clock hold test done");
  endtask : t_hold

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tc0_match = 1'b0;
    go = 1'b0;
    tx_byte = 8'h00;
    fails = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_strobe();
    t_timer();
    t_toggle();
    t_ext();
    t_hold();
    end_of_test();
  end
endmodule : test_serial_shift_clock_select

`default_nettype wire
